/* File: shared/vf_pkg.sv */
// constants for the frequency limit and v/f shaping block
// frequencies are in 0.1 Hz units, voltages in whole volts
package vf_pkg;
   localparam int          FW            = 16;
   localparam int          NTERM         = 12;
   localparam int          NSKIP         = 6;
   localparam int          SYNC_W        = NTERM + 3;
   // special codes
   localparam logic [15:0] CODE_OFF      = 16'h270f;  // 9999
   localparam logic [15:0] CODE_95PCT    = 16'h22b8;  // 8888
   localparam logic [15:0] FREQ_MAX      = 16'h0fa0;  // 400 Hz
   localparam logic [15:0] VOLT_MAX      = 16'h03e8;  // 1000 V
   localparam logic [15:0] MOTOR_5PT     = 16'h0002;
   localparam logic [15:0] MAP_SECOND    = 16'h0003;
   localparam logic [31:0] PCT_95        = 32'h0000005f;
   localparam logic [31:0] PCT_100       = 32'h00000064;
   localparam int          DEDICATED_IDX = 0;
   // reset values
   localparam logic [15:0] RST_UPPER     = 16'h04b0;  // 120 Hz
   localparam logic [15:0] RST_LOWER     = 16'h0000;
   localparam logic [15:0] RST_JOG       = 16'h0032;  // 5 Hz
   localparam logic [15:0] RST_THR       = 16'h0005;  // 0.5 Hz
   localparam logic [15:0] RST_KNEE_F    = 16'h0258;  // 60 Hz
   localparam logic [15:0] RST_KNEE_V    = 16'h270f;
   localparam logic [15:0] RST_ALT_KNEE  = 16'h270f;
   localparam logic [15:0] RST_MOTOR     = 16'h0000;
   localparam logic [15:0] RST_CURVE     = 16'h0001;
   localparam logic [15:0] RST_SKIP      = 16'h270f;
   localparam logic [15:0] RST_MAP       = 16'h270f;
   // accel time: clk cycles per 0.1 Hz step of the running frequency
   localparam logic [15:0] RST_ACC_STEP  = 16'h03e8;
   // register byte offsets
   localparam logic [7:0]  A_UPPER       = 8'h00;
   localparam logic [7:0]  A_LOWER       = 8'h04;
   localparam logic [7:0]  A_EXT_UPPER   = 8'h08;
   localparam logic [7:0]  A_JOG         = 8'h0c;
   localparam logic [7:0]  A_THR         = 8'h10;
   localparam logic [7:0]  A_KNEE_F      = 8'h14;
   localparam logic [7:0]  A_KNEE_V      = 8'h18;
   localparam logic [7:0]  A_ALT_KNEE    = 8'h1c;
   localparam logic [7:0]  A_MOTOR       = 8'h20;
   localparam logic [7:0]  A_CURVE       = 8'h24;
   localparam logic [7:0]  A_ACC_STEP    = 8'h28;
   localparam logic [7:0]  A_SKIP0       = 8'h30;
   localparam logic [7:0]  A_MAP0        = 8'h50;
   localparam logic [7:0]  A_RUN_FREQ    = 8'h80;
   localparam logic [7:0]  A_TARGET      = 8'h84;
   localparam logic [7:0]  A_VOLT        = 8'h88;
   localparam logic [7:0]  A_STATUS      = 8'h8c;
endpackage : vf_pkg

/* File: src/pin_sync.sv */
// two-flop synchroniser for terminal and control inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
module pin_sync
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic [vf_pkg::SYNC_W-1:0] async_in,
   output logic      [vf_pkg::SYNC_W-1:0] sync_out
);
   logic [vf_pkg::SYNC_W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : pin_sync

/* File: src/vf_curve.sv */
// output voltage from running frequency, knee point and curve select
// assumes knee inputs are registered and steady
`timescale 1ns/1ps
module vf_curve
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [15:0] freq,
   input  wire logic [15:0] knee_f,
   input  wire logic [15:0] knee_v,
   input  wire logic        square,
   output logic      [15:0] volt_q
);
   logic [31:0] lin_num;
   logic [31:0] lin;
   logic [47:0] sq_num;
   logic [31:0] sq_den;
   logic [47:0] sq;
   logic [15:0] volt_d;

   assign lin_num = knee_v * freq;
   assign lin     = (knee_f == 16'h0000) ? 32'h0 : lin_num / knee_f;
   assign sq_num  = lin_num * freq;
   assign sq_den  = knee_f * knee_f;
   assign sq      = (sq_den == 32'h0) ? 48'h0 : sq_num / sq_den;

   always_comb
   begin
      if (freq >= knee_f)
         volt_d = knee_v;
      else if (square)
         volt_d = sq[15:0];
      else
         volt_d = lin[15:0];
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         volt_q <= 16'h0000;
      else
         volt_q <= volt_d;
   end
endmodule : vf_curve

/* File: src/freq_vf_shaper.sv */
// frequency limiting, skip bands, ramp and v/f shaping, register port
// assumes freq_cmd and supply_volt come from logic on clk; pins are async
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module freq_vf_shaper
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic [7:0]             addr,
   input  wire logic [15:0]            wdata,
   input  wire logic                   wr_en,
   input  wire logic                   rd_en,
   output logic      [15:0]            rdata,
   input  wire logic [15:0]            freq_cmd,
   input  wire logic [15:0]            supply_volt,
   input  wire logic                   start_in,
   input  wire logic                   jog_in,
   input  wire logic                   stall_in,
   input  wire logic [vf_pkg::NTERM-1:0] term_in,
   output logic      [15:0]            run_freq,
   output logic      [15:0]            volt_out,
   output logic                        second_set_active,
   output logic                        ramping
);
   logic [15:0] upper_q, lower_q, jog_q, thr_q, knee_f_q, knee_v_q;
   logic [15:0] alt_knee_q, motor_q, curve_q, acc_step_q;
   logic [15:0] skip_q [vf_pkg::NSKIP];
   logic [15:0] map_q  [vf_pkg::NTERM];
   logic [15:0] target_q, run_q, cnt_q, eff_kf_q, eff_kv_q;
   logic [15:0] s1, s2, s3, clamped, target_d;
   logic [31:0] v95;
   logic [vf_pkg::SYNC_W-1:0] sync;
   logic [vf_pkg::NTERM-1:0]  sel_hit;
   logic        start_s, jog_s, stall_s, tick, sec_q, ramp_q;

   function automatic logic valid_freq(input logic [15:0] v);
      valid_freq = (v <= vf_pkg::FREQ_MAX);
   endfunction : valid_freq

   function automatic logic [15:0] skip_band(input logic [15:0] f,
                                             input logic [15:0] a,
                                             input logic [15:0] b);
      logic [15:0] lo;
      logic [15:0] hi;
      lo = (a < b) ? a : b;
      hi = (a < b) ? b : a;
      if (a != vf_pkg::CODE_OFF && b != vf_pkg::CODE_OFF && f >= lo && f <= hi)
         skip_band = a;
      else
         skip_band = f;
   endfunction : skip_band

   function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
      min16 = (a < b) ? a : b;
   endfunction : min16

   pin_sync u_sync
   (
      .clk      (clk),
      .rst      (rst),
      .async_in ({stall_in, jog_in, start_in, term_in}),
      .sync_out (sync)
   );
   assign start_s = sync[vf_pkg::NTERM];
   assign jog_s   = sync[vf_pkg::NTERM+1];
   assign stall_s = sync[vf_pkg::NTERM+2];

   // one shared upper limit: writing either address updates both views
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         upper_q <= vf_pkg::RST_UPPER;
         lower_q <= vf_pkg::RST_LOWER;
         jog_q   <= vf_pkg::RST_JOG;
         thr_q   <= vf_pkg::RST_THR;
      end
      else if (wr_en && valid_freq(wdata))
      begin
         if (addr == vf_pkg::A_UPPER || addr == vf_pkg::A_EXT_UPPER)
            upper_q <= wdata;
         else if (addr == vf_pkg::A_LOWER)
            lower_q <= wdata;
         else if (addr == vf_pkg::A_JOG)
            jog_q <= wdata;
         else if (addr == vf_pkg::A_THR)
            thr_q <= wdata;
      end
   end

   // knee settings; out-of-range writes are dropped
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         knee_f_q   <= vf_pkg::RST_KNEE_F;
         knee_v_q   <= vf_pkg::RST_KNEE_V;
         alt_knee_q <= vf_pkg::RST_ALT_KNEE;
         motor_q    <= vf_pkg::RST_MOTOR;
         curve_q    <= vf_pkg::RST_CURVE;
         acc_step_q <= vf_pkg::RST_ACC_STEP;
      end
      else if (wr_en)
      begin
         if (addr == vf_pkg::A_KNEE_F && valid_freq(wdata))
            knee_f_q <= wdata;
         else if (addr == vf_pkg::A_KNEE_V)
         begin
            if (wdata <= vf_pkg::VOLT_MAX)
               knee_v_q <= wdata;
            else if ((wdata == vf_pkg::CODE_OFF || wdata == vf_pkg::CODE_95PCT)
                     && motor_q != vf_pkg::MOTOR_5PT)
               knee_v_q <= wdata;
         end
         else if (addr == vf_pkg::A_ALT_KNEE
                  && (valid_freq(wdata) || wdata == vf_pkg::CODE_OFF))
            alt_knee_q <= wdata;
         else if (addr == vf_pkg::A_MOTOR)
            motor_q <= wdata;
         else if (addr == vf_pkg::A_CURVE && wdata <= 16'h0001)
            curve_q <= wdata;
         else if (addr == vf_pkg::A_ACC_STEP && wdata != 16'h0000)
            acc_step_q <= wdata;
      end
   end

   // skip bounds and terminal map
   genvar g;
   generate
      for (g = 0; g < vf_pkg::NSKIP; g++)
      begin : g_skip
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               skip_q[g] <= vf_pkg::RST_SKIP;
            else if (wr_en && addr == vf_pkg::A_SKIP0 + 8'(4*g)
                     && (valid_freq(wdata) || wdata == vf_pkg::CODE_OFF))
               skip_q[g] <= wdata;
         end
      end
      for (g = 0; g < vf_pkg::NTERM; g++)
      begin : g_map
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               map_q[g] <= (g == vf_pkg::DEDICATED_IDX) ? vf_pkg::MAP_SECOND
                                                       : vf_pkg::RST_MAP;
            else if (wr_en && addr == vf_pkg::A_MAP0 + 8'(4*g))
               map_q[g] <= wdata;
         end
         assign sel_hit[g] = sync[g] && map_q[g] == vf_pkg::MAP_SECOND;
      end
   endgenerate

   // skip first, then clamp; bands checked in listed order
   assign s1 = skip_band(freq_cmd, skip_q[0], skip_q[1]);
   assign s2 = skip_band(s1, skip_q[2], skip_q[3]);
   assign s3 = skip_band(s2, skip_q[4], skip_q[5]);
   assign clamped = (min16(s3, upper_q) < lower_q) ? lower_q
                                                   : min16(s3, upper_q);

   always_comb
   begin
      target_d = 16'h0000;
      if (jog_s)
      begin
         if (jog_q <= lower_q)
            target_d = jog_q;
         else
            target_d = min16(jog_q, upper_q);
      end
      else if (start_s)
      begin
         if (lower_q > thr_q)
            target_d = clamped;
         else if (freq_cmd >= thr_q)
            target_d = clamped;
      end
   end

   // ramp divider: one step per acc_step_q cycles
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cnt_q <= 16'h0000;
      else if (cnt_q >= acc_step_q - 16'h0001)
         cnt_q <= 16'h0000;
      else
         cnt_q <= cnt_q + 16'h0001;
   end
   assign tick = (cnt_q >= acc_step_q - 16'h0001);

   // running frequency walks through skip bands while ramping
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         target_q <= 16'h0000;
         run_q    <= 16'h0000;
         ramp_q   <= 1'b0;
      end
      else
      begin
         target_q <= target_d;
         ramp_q   <= (run_q != target_q);
         if (tick)
         begin
            if (stall_s && run_q != 16'h0000)
               run_q <= run_q - 16'h0001;
            else if (!stall_s && run_q < target_q)
               run_q <= run_q + 16'h0001;
            else if (!stall_s && run_q > target_q)
               run_q <= run_q - 16'h0001;
         end
      end
   end

   // effective knee point
   assign v95 = (32'(supply_volt) * vf_pkg::PCT_95) / vf_pkg::PCT_100;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sec_q    <= 1'b0;
         eff_kf_q <= vf_pkg::RST_KNEE_F;
         eff_kv_q <= 16'h0000;
      end
      else
      begin
         sec_q <= |sel_hit;
         if (sec_q && alt_knee_q != vf_pkg::CODE_OFF && motor_q != vf_pkg::MOTOR_5PT)
            eff_kf_q <= alt_knee_q;
         else
            eff_kf_q <= knee_f_q;
         if (knee_v_q == vf_pkg::CODE_OFF)
            eff_kv_q <= supply_volt;
         else if (knee_v_q == vf_pkg::CODE_95PCT)
            eff_kv_q <= v95[15:0];
         else
            eff_kv_q <= min16(knee_v_q, supply_volt);
      end
   end

   vf_curve u_curve
   (
      .clk    (clk),
      .rst    (rst),
      .freq   (run_q),
      .knee_f (eff_kf_q),
      .knee_v (eff_kv_q),
      .square (curve_q[0]),
      .volt_q (volt_out)
   );

   assign run_freq          = run_q;
   assign second_set_active = sec_q;
   assign ramping           = ramp_q;

   // read port; unmapped addresses return zero
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rdata <= 16'h0000;
      else if (rd_en)
      begin
         if (addr == vf_pkg::A_UPPER || addr == vf_pkg::A_EXT_UPPER)
            rdata <= upper_q;
         else if (addr == vf_pkg::A_LOWER)
            rdata <= lower_q;
         else if (addr == vf_pkg::A_JOG)
            rdata <= jog_q;
         else if (addr == vf_pkg::A_THR)
            rdata <= thr_q;
         else if (addr == vf_pkg::A_KNEE_F)
            rdata <= knee_f_q;
         else if (addr == vf_pkg::A_KNEE_V)
            rdata <= knee_v_q;
         else if (addr == vf_pkg::A_ALT_KNEE)
            rdata <= alt_knee_q;
         else if (addr == vf_pkg::A_MOTOR)
            rdata <= motor_q;
         else if (addr == vf_pkg::A_CURVE)
            rdata <= curve_q;
         else if (addr == vf_pkg::A_ACC_STEP)
            rdata <= acc_step_q;
         else if (addr >= vf_pkg::A_SKIP0 && addr < vf_pkg::A_SKIP0 + 8'h18
                  && addr[1:0] == 2'b00)
            rdata <= skip_q[3'((addr - vf_pkg::A_SKIP0) >> 2)];
         else if (addr >= vf_pkg::A_MAP0 && addr < vf_pkg::A_MAP0 + 8'h30
                  && addr[1:0] == 2'b00)
            rdata <= map_q[4'((addr - vf_pkg::A_MAP0) >> 2)];
         else if (addr == vf_pkg::A_RUN_FREQ)
            rdata <= run_q;
         else if (addr == vf_pkg::A_TARGET)
            rdata <= target_q;
         else if (addr == vf_pkg::A_VOLT)
            rdata <= volt_out;
         else if (addr == vf_pkg::A_STATUS)
            rdata <= {13'h0000, stall_s, ramp_q, sec_q};
         else
            rdata <= 16'h0000;
      end
   end
endmodule : freq_vf_shaper

/* File: sim/cmd_supply_model.sv */
// frequency command source and supply rail facing the shaper
// assumes the bench sets the requested command and supply level
`timescale 1ns/1ps
module cmd_supply_model
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [15:0] cmd_req,
   input  wire logic [15:0] volt_req,
   output logic      [15:0] freq_cmd,
   output logic      [15:0] supply_volt
);
   // source is logic on clk, so it only moves just after an edge
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         freq_cmd    <= 16'h0000;
         supply_volt <= 16'h0000;
      end
      else
      begin
         freq_cmd    <= cmd_req;
         supply_volt <= volt_req;
      end
   end
endmodule : cmd_supply_model

/* File: sim/freq_vf_shaper_asserts.sv */
// port assertions for the frequency limit and v/f shaper
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
module freq_vf_shaper_asserts
(
   input wire logic                       clk,
   input wire logic                       rst,
   input wire logic [7:0]                 addr,
   input wire logic [15:0]                wdata,
   input wire logic                       wr_en,
   input wire logic                       rd_en,
   input wire logic [15:0]                rdata,
   input wire logic [15:0]                freq_cmd,
   input wire logic [15:0]                supply_volt,
   input wire logic                       start_in,
   input wire logic                       jog_in,
   input wire logic                       stall_in,
   input wire logic [vf_pkg::NTERM-1:0]   term_in,
   input wire logic [15:0]                run_freq,
   input wire logic [15:0]                volt_out,
   input wire logic                       second_set_active,
   input wire logic                       ramping
);
   logic [3:0] stall_hist_q;
   logic       any_term;
   assign any_term = |term_in;
   // stall reaches the ramp through the pin synchroniser, so look back
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         stall_hist_q <= 4'h0;
      else
         stall_hist_q <= {stall_hist_q[2:0], stall_in};
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence stall_held;
      stall_in [*5];
   endsequence
   sequence unmapped_read;
      rd_en && addr == 8'hfc;
   endsequence
   a_run_one_step : assert property
      ((run_freq - $past(run_freq) + 16'h0001) <= 16'h0002)
      else $error("running frequency jumped");
   a_stall_no_rise : assert property
      (stall_held |=> run_freq <= $past(run_freq))
      else $error("running frequency rose during stall");
   a_run_below_max : assert property
      (run_freq <= vf_pkg::FREQ_MAX)
      else $error("running frequency above range");
   a_volt_capped : assert property
      ($stable(supply_volt) [*3] |-> volt_out <= supply_volt)
      else $error("voltage above supply");
   a_ramp_flag_set : assert property
      ($changed(run_freq) && stall_hist_q == 4'h0 && !stall_in |-> ##[0:1] ramping)
      else $error("ramp moved without ramping flag");
   a_rdata_holds : assert property
      (!$past(rd_en) |-> $stable(rdata))
      else $error("read data changed without a read");
   a_unmapped_zero : assert property
      (unmapped_read |=> rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_second_from_pin : assert property
      ($rose(second_set_active) |-> $past(any_term, 2) || $past(any_term, 3))
      else $error("second set rose without a terminal");
endmodule : freq_vf_shaper_asserts

bind freq_vf_shaper freq_vf_shaper_asserts freq_vf_shaper_asserts_i
(
   .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
   .rdata(rdata), .freq_cmd(freq_cmd), .supply_volt(supply_volt), .start_in(start_in),
   .jog_in(jog_in), .stall_in(stall_in), .term_in(term_in), .run_freq(run_freq),
   .volt_out(volt_out), .second_set_active(second_set_active), .ramping(ramping)
);

/* File: sim/freq_vf_shaper_tb.sv */
// self-checking bench for the frequency limit and v/f shaper
// assumes the command source model and the bound checker
`timescale 1ns/1ps
module freq_vf_shaper_tb;
   logic                     clk, rst, wr_en, rd_en, start_in, jog_in, stall_in;
   logic [7:0]               addr;
   logic [15:0]              wdata, rdata, cmd_req, volt_req, freq_cmd, supply_volt;
   logic [15:0]              run_freq, volt_out;
   logic [vf_pkg::NTERM-1:0] term_in;
   logic                     second_set_active, ramping;
   int                       num_errors, cmp_count;
   logic [7:0]               ra [15];
   logic [15:0]              rv [15];
   logic [15:0]              sk [9];

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   cmd_supply_model cmd_supply_model_i (.clk(clk), .rst(rst), .cmd_req(cmd_req),
      .volt_req(volt_req), .freq_cmd(freq_cmd), .supply_volt(supply_volt));
   freq_vf_shaper freq_vf_shaper_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .freq_cmd(freq_cmd),
      .supply_volt(supply_volt), .start_in(start_in), .jog_in(jog_in),
      .stall_in(stall_in), .term_in(term_in), .run_freq(run_freq), .volt_out(volt_out),
      .second_set_active(second_set_active), .ramping(ramping));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk(rdata, e);
   endtask : rd

   // bounded wait on running frequency (v=0) or output voltage (v=1)
   task automatic wt(input logic v, input logic [15:0] e);
      int n;
      n = 0;
      while ((v ? volt_out : run_freq) !== e && n < 5000)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(v ? volt_out : run_freq, e);
   endtask : wt

   task automatic wrap_up();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   initial
   begin
      rst = 1'b1;
      {addr, wdata, wr_en, rd_en, start_in, jog_in, stall_in, term_in} = '0;
      cmd_req = 16'h0000;
      volt_req = 16'h0190;
      num_errors = 0;
      cmp_count = 0;
      ra = '{8'h00, 8'h08, 8'h04, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24,
             8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44, 8'hfc};
      rv = '{16'h04b0, 16'h04b0, 16'h0000, 16'h0258, 16'h270f, 16'h270f, 16'h0000,
             16'h0001, 16'h270f, 16'h270f, 16'h270f, 16'h270f, 16'h270f, 16'h270f,
             16'h0000};
      // bands: command inside each band; band 2 written upside down
      sk = '{16'h012c, 16'h0190, 16'h015e, 16'h0258, 16'h01f4, 16'h0226,
             16'h0064, 16'h0096, 16'h0078};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 15; i++)
         rd(ra[i], rv[i]);
      wr(8'h28, 16'h0001);
      wr(8'h08, 16'h0fa0);
      rd(8'h00, 16'h0fa0);
      wr(8'h00, 16'h0320);
      rd(8'h08, 16'h0320);
      wr(8'h14, 16'h0fa1);
      rd(8'h14, 16'h0258);
      wr(8'h18, 16'h03e9);
      rd(8'h18, 16'h270f);
      wr(8'h18, 16'h22b8);
      rd(8'h18, 16'h22b8);
      wr(8'h24, 16'h0002);
      rd(8'h24, 16'h0001);
      start_in <= 1'b1;
      cmd_req <= 16'h03e8;
      wt(1'b0, 16'h0320);
      // ramp flag is one clock behind the running frequency
      @(posedge clk);
      #1;
      chk({15'h0000, ramping}, 16'h0000);
      rd(8'h80, 16'h0320);
      rd(8'h84, 16'h0320);
      rd(8'h88, 16'h017c);
      rd(8'h8c, 16'h0000);
      cmd_req <= 16'h0000;
      start_in <= 1'b0;
      wt(1'b0, 16'h0000);
      wr(8'h04, 16'h00c8);
      start_in <= 1'b1;
      wt(1'b0, 16'h00c8);
      wr(8'h0c, 16'h0096);
      jog_in <= 1'b1;
      wt(1'b0, 16'h0096);
      jog_in <= 1'b0;
      stall_in <= 1'b1;
      wt(1'b0, 16'h0000);
      stall_in <= 1'b0;
      wr(8'h04, 16'h0000);
      for (int i = 0; i < 3; i++)
      begin
         wr(8'h30 + 8'(i * 8), sk[3 * i]);
         wr(8'h34 + 8'(i * 8), sk[3 * i + 1]);
      end
      for (int i = 0; i < 3; i++)
      begin
         cmd_req <= sk[3 * i + 2];
         wt(1'b0, sk[3 * i]);
      end
      // crossing all three bands on the way up must not stall the ramp
      cmd_req <= 16'h02bc;
      repeat (8) @(posedge clk);
      #1;
      chk({15'h0000, ramping}, 16'h0001);
      wt(1'b0, 16'h02bc);
      wr(8'h18, 16'h00c8);
      wr(8'h24, 16'h0000);
      cmd_req <= 16'h012c;
      wt(1'b1, 16'h0064);
      wr(8'h24, 16'h0001);
      wt(1'b1, 16'h0032);
      cmd_req <= 16'h02bc;
      wt(1'b1, 16'h00c8);
      wr(8'h18, 16'h270f);
      wt(1'b1, 16'h0190);
      wr(8'h18, 16'h22b8);
      wt(1'b1, 16'h017c);
      wr(8'h18, 16'h00c8);
      wr(8'h24, 16'h0000);
      cmd_req <= 16'h012c;
      wt(1'b1, 16'h0064);
      wr(8'h1c, 16'h012c);
      term_in <= 12'h001;
      wt(1'b1, 16'h00c8);
      chk({15'h0000, second_set_active}, 16'h0001);
      wr(8'h20, 16'h0002);
      wt(1'b1, 16'h0064);
      wr(8'h18, 16'h270f);
      rd(8'h18, 16'h00c8);
      wr(8'h20, 16'h0000);
      wt(1'b1, 16'h00c8);
      term_in <= 12'h000;
      wt(1'b1, 16'h0064);
      wr(8'h5c, 16'h0003);
      term_in <= 12'h008;
      wt(1'b1, 16'h00c8);
      chk({15'h0000, second_set_active}, 16'h0001);
      wrap_up();
   end

   // whole run is a few thousand cycles; this is far past it
   initial
   begin
      #500000;
      num_errors++;
      wrap_up();
   end
endmodule : freq_vf_shaper_tb
